// >>> csc_pkg.sv
package csc_pkg;

    // Register byte addresses on the Wishbone slave
    localparam logic [3:0] CSC_ADDR_PMR    = 4'h0;
    localparam logic [3:0] CSC_ADDR_POWER_CONTROL_REG   = 4'h4;
    localparam logic [3:0] CSC_ADDR_RCON   = 4'h8;
    localparam logic [3:0] CSC_ADDR_STATUS = 4'hc;

    // Power management register fields
    localparam int CSC_PMR_CD_HI   = 7;
    localparam int CSC_PMR_CD_LO   = 6;
    localparam int CSC_PMR_SPEEDUP = 5;
    localparam int CSC_PMR_MULT_EN = 4;
    localparam int CSC_PMR_FACTOR  = 3;

    // Power control register fields
    localparam int CSC_POWER_CONTROL_REG_FAIL_FLAG = 5;
    localparam int CSC_POWER_CONTROL_REG_DETECT_EN = 4;

    // Ring control register fields
    localparam int CSC_RCON_READY = 3;
    localparam int CSC_RCON_RING  = 2;

    // Status register fields
    localparam int CSC_ST_PFAIL = 7;
    localparam int CSC_ST_HIGH  = 6;
    localparam int CSC_ST_LOW   = 5;

    typedef enum logic [1:0]
    {
        CSC_CD_MULT = 2'b00,
        CSC_CD_RSVD = 2'b01,
        CSC_CD_DIV4 = 2'b10,
        CSC_CD_SLOW = 2'b11
    } csc_cd_t;

    // Slow mode divides the oscillator by this before the fixed divide-by-4
    localparam int CSC_SLOW_DIV  = 256;
    localparam int CSC_STATE_DIV = 4;
    localparam logic [7:0] CSC_SLOW_MAX = 8'(CSC_SLOW_DIV - 1);

    // Fail threshold: a gap between oscillator edges longer than 1/40 kHz is a failure
    localparam int CSC_FAIL_HZ  = 40000;
    localparam int CSC_CLK_HZ   = 40000000;
    localparam int CSC_FAIL_CYC = (CSC_CLK_HZ + CSC_FAIL_HZ - 1) / CSC_FAIL_HZ;
    localparam logic [10:0] CSC_FAIL_CNT = 11'(CSC_FAIL_CYC);

    localparam logic [7:0] CSC_PMR_RST  = 8'h80;
    localparam logic [7:0] CSC_POWER_CONTROL_REG_RST = 8'h00;

    typedef struct packed
    {
        logic       irq_ack;
        logic [2:0] level_active;
        logic [3:0] serial_busy;
        logic       rx_start;
        logic       tx_load;
    } csc_cpu_t;

endpackage

// >>> csc_clock_control.sv
`timescale 1ns/10ps
// What this block does
// - Ready low, multiplier select refused while stabilizing
// - Only hardware sets ready after stabilization
// - Hold processor reset while oscillator below 40kHz
// - Fail detect enabled by power control bit 4
// - Fail flag bit 5 set on any failure
// - Fail flag cleared by power-up or write zero
// - Stop does not disable fail detection
// - Slow mode divides oscillator by 256
// - Only software selects slow mode
// - Default four oscillator clocks per cycle
// - Speedup active only with enable bit set
// - Acknowledged interrupt in slow mode restores divide-by-4
// - Serial start bit or transmit load restores speed
// - Stay divide-by-4 until software reselects slow
// - Divide field writes ignored during serial activity
// - Status 7-5 show serviced priority levels
// - Status 0-3 show serial port activity
// - Locked-out interrupts never trigger speedup
// - Divide field encoding, divide-by-4 default
// - Divide changes must pass through divide-by-4
// - Enable changes only in divide-by-4, switching it off restarts stabilization
module csc_clock_control
#(
    parameter int STAB_CYCLES = 65536
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             por_i,
    input  wire logic             osc_i,
    input  wire csc_pkg::csc_cpu_t cpu_i,
    input  wire logic [3:0]       wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic             wb_we_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    output logic                  cpu_reset_o,
    output logic [1:0]            clk_sel_o,
    output logic                  mult_factor_sel_o,
    output logic                  mult_enable_o,
    output logic                  machine_tick_o
);
    import csc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [1:0]  clk_divide_sel_r;
    logic        auto_speedup_en_r;
    logic        mult_enable_r;
    logic        mult_factor_sel_r;
    logic        osc_fail_detect_en_r;
    logic        osc_fail_flag_r;
    logic        mult_clock_ready_r;
    logic [16:0] stab_cnt_r;
    // Oscillator monitor
    logic        osc_meta_r;
    logic        osc_sync_r;
    logic        osc_prev_r;
    logic [10:0] period_cnt_r;
    logic        osc_low_r;
    logic [7:0]  slow_cnt_r;
    logic [1:0]  state_cnt_r;
    // Decode and events
    logic        sys_tick;
    logic        wr_stb;
    logic        wr_pmr;
    logic        wr_power_control_reg;
    logic        serial_active;
    logic        speedup_event;
    logic [1:0]  cd_wr;
    logic        div4_sel;
    logic        mult_ok;

    localparam logic [16:0] STAB_MAX = 17'(STAB_CYCLES);

    // Divide-by-4 is the hub: every change of the divide field starts or ends there
    function automatic logic cd_move_ok(input logic [1:0] cur, input logic [1:0] nxt);
        cd_move_ok = (cur == nxt) || (cur == CSC_CD_DIV4) || (nxt == CSC_CD_DIV4);
    endfunction

    // A divide write lands only if the code is defined, the move is allowed and,
    // for the multiplier, its clock is enabled and settled
    function automatic logic cd_write_ok
    (
        input logic [1:0] cur,
        input logic [1:0] nxt,
        input logic       mult_ready
    );
        cd_write_ok = (nxt != CSC_CD_RSVD)
                    && cd_move_ok(cur, nxt)
                    && ((nxt != CSC_CD_MULT) || mult_ready);
    endfunction

    // Gating with ack makes each request write exactly once
    assign wr_stb        = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign wr_pmr        = wr_stb && (wb_adr_i == CSC_ADDR_PMR);
    assign wr_power_control_reg       = wr_stb && (wb_adr_i == CSC_ADDR_POWER_CONTROL_REG);
    assign cd_wr         = wb_dat_i[CSC_PMR_CD_HI:CSC_PMR_CD_LO];
    assign serial_active = |cpu_i.serial_busy;
    assign div4_sel      = (clk_divide_sel_r == CSC_CD_DIV4);
    // Ready alone is not enough: a settled but disabled multiplier is refused too
    assign mult_ok       = mult_clock_ready_r && mult_enable_r;
    // The CPU only flags irq_ack for sources it will really take, so masked or
    // priority-locked sources never reach here
    assign speedup_event = auto_speedup_en_r && (clk_divide_sel_r == CSC_CD_SLOW)
                         && (cpu_i.irq_ack
                             || cpu_i.rx_start || cpu_i.tx_load);

    ////////////////////////////////////////////////////////////////////////////
    // Clock divide field
    // Reset and every switchback land in divide-by-4
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clk_divide_sel_r <= CSC_CD_DIV4;
        end
        else if (ce_i)
        begin
            // A write racing a speedup event loses, so a switchback is never undone
            if (speedup_event)
            begin
                clk_divide_sel_r <= CSC_CD_DIV4;
            end
            else if (wr_pmr && !serial_active
                     && cd_write_ok(clk_divide_sel_r, cd_wr, mult_ok))
            begin
                clk_divide_sel_r <= cd_wr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Multiplier controls and speedup enable
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            auto_speedup_en_r <= CSC_PMR_RST[CSC_PMR_SPEEDUP];
            mult_enable_r     <= CSC_PMR_RST[CSC_PMR_MULT_EN];
            mult_factor_sel_r <= CSC_PMR_RST[CSC_PMR_FACTOR];
        end
        else if (ce_i && wr_pmr)
        begin
            auto_speedup_en_r <= wb_dat_i[CSC_PMR_SPEEDUP];
            // Factor may only move while the multiplier is off
            if (!mult_enable_r)
            begin
                mult_factor_sel_r <= wb_dat_i[CSC_PMR_FACTOR];
            end
            // Ring mode is never entered here, so divide-by-4 is the only gate
            if (div4_sel)
            begin
                mult_enable_r <= wb_dat_i[CSC_PMR_MULT_EN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stabilization timeout, restarted when the multiplier is switched off
    // Ready then holds until the next switch-off; the count parks at its end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stab_cnt_r         <= '0;
            mult_clock_ready_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (wr_pmr && mult_enable_r && !wb_dat_i[CSC_PMR_MULT_EN]
                && div4_sel)
            begin
                stab_cnt_r         <= '0;
                mult_clock_ready_r <= 1'b0;
            end
            else if (stab_cnt_r >= STAB_MAX - 17'h1)
            begin
                mult_clock_ready_r <= 1'b1;
            end
            else
            begin
                stab_cnt_r <= stab_cnt_r + 17'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator-fail detection; the flag survives every reset but power-up
    // The monitor has no reset: it must keep watching through every core reset
    always_ff @(posedge clk_i)
    begin
        osc_meta_r <= osc_i;
        osc_sync_r <= osc_meta_r;
        osc_prev_r <= osc_sync_r;
        if (osc_sync_r != osc_prev_r)
        begin
            period_cnt_r <= '0;
            osc_low_r    <= 1'b0;
        end
        else if (period_cnt_r >= CSC_FAIL_CNT)
        begin
            osc_low_r <= 1'b1;
        end
        else
        begin
            period_cnt_r <= period_cnt_r + 11'h1;
        end
    end

    // Detection keeps running with ce_i low, as in stop, so a dead clock is seen
    always_ff @(posedge clk_i)
    begin
        if (por_i)
        begin
            osc_fail_flag_r      <= 1'b0;
            osc_fail_detect_en_r <= CSC_POWER_CONTROL_REG_RST[CSC_POWER_CONTROL_REG_DETECT_EN];
            cpu_reset_o          <= 1'b0;
        end
        else
        begin
            if (osc_low_r)
            begin
                osc_fail_flag_r <= 1'b1;
            end
            else if (ce_i && wr_power_control_reg && !wb_dat_i[CSC_POWER_CONTROL_REG_FAIL_FLAG])
            begin
                osc_fail_flag_r <= 1'b0;
            end
            if (ce_i && wr_power_control_reg)
            begin
                osc_fail_detect_en_r <= wb_dat_i[CSC_POWER_CONTROL_REG_DETECT_EN];
            end
            // Follows the live detector, so the reset lifts by itself once the clock is back
            cpu_reset_o <= osc_low_r && osc_fail_detect_en_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System clock enable and machine cycle tick
    // Slow mode stretches each system tick to 256 clocks; the four-state divider is shared
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            slow_cnt_r     <= '0;
            state_cnt_r    <= '0;
            machine_tick_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (clk_divide_sel_r == CSC_CD_SLOW)
            begin
                slow_cnt_r <= (slow_cnt_r == CSC_SLOW_MAX) ? 8'h00 : slow_cnt_r + 8'h01;
            end
            else
            begin
                slow_cnt_r <= '0;
            end
            if (sys_tick)
            begin
                state_cnt_r <= state_cnt_r + 2'h1;
            end
            machine_tick_o <= sys_tick && (state_cnt_r == 2'(CSC_STATE_DIV - 1));
        end
    end

    assign sys_tick = (clk_divide_sel_r != CSC_CD_SLOW) || (slow_cnt_r == CSC_SLOW_MAX);

    // Outputs are registered copies, one clock behind the state they show
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clk_sel_o         <= CSC_CD_DIV4;
            mult_factor_sel_o <= CSC_PMR_RST[CSC_PMR_FACTOR];
            mult_enable_o     <= CSC_PMR_RST[CSC_PMR_MULT_EN];
        end
        else if (ce_i)
        begin
            clk_sel_o         <= clk_divide_sel_r;
            mult_factor_sel_o <= mult_factor_sel_r;
            mult_enable_o     <= mult_enable_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone classic slave: one wait state, unmapped reads return zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else if (ce_i)
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= '0;
            case (wb_adr_i)
                CSC_ADDR_PMR:
                begin
                    wb_dat_o[CSC_PMR_CD_HI:CSC_PMR_CD_LO] <= clk_divide_sel_r;
                    wb_dat_o[CSC_PMR_SPEEDUP]             <= auto_speedup_en_r;
                    wb_dat_o[CSC_PMR_MULT_EN]             <= mult_enable_r;
                    wb_dat_o[CSC_PMR_FACTOR]              <= mult_factor_sel_r;
                end
                CSC_ADDR_POWER_CONTROL_REG:
                begin
                    wb_dat_o[CSC_POWER_CONTROL_REG_FAIL_FLAG] <= osc_fail_flag_r;
                    wb_dat_o[CSC_POWER_CONTROL_REG_DETECT_EN] <= osc_fail_detect_en_r;
                end
                CSC_ADDR_RCON:
                begin
                    wb_dat_o[CSC_RCON_READY] <= mult_clock_ready_r;
                    // No ring oscillator here, so ring mode always reads clear
                    wb_dat_o[CSC_RCON_RING]  <= 1'b0;
                end
                CSC_ADDR_STATUS:
                begin
                    // Status comes live from the core; nothing here latches it
                    wb_dat_o[CSC_ST_PFAIL:CSC_ST_LOW] <= cpu_i.level_active;
                    wb_dat_o[3:0]                     <= cpu_i.serial_busy;
                end
                default:
                begin
                    wb_dat_o <= '0;
                end
            endcase
        end
    end

endmodule

// >>> csc_clock_control_chk.sv
`timescale 1ns/10ps
module csc_clock_control_chk
#(
    parameter int STAB_CYCLES = 65536
)
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       ce_i,
    input wire logic       por_i,
    input wire logic       osc_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic       wb_we_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       cpu_reset_o,
    input wire logic [1:0] clk_sel_o,
    input wire logic       mult_factor_sel_o,
    input wire logic       mult_enable_o,
    input wire logic       machine_tick_o
);
    import csc_pkg::*;
    logic        osc_d_r = 1'b0;
    logic [10:0] idle_r  = 11'h000;
    logic        pmr_wr;
    assign pmr_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & (wb_adr_i == CSC_ADDR_PMR);
    // Raw idle time of the oscillator; saturates so a dead clock never wraps
    always_ff @(posedge clk_i)
    begin
        osc_d_r <= osc_i;
        idle_r  <= (osc_i != osc_d_r) ? 11'h000 : idle_r + {10'h000, ~&idle_r};
    end
////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    // A frozen block holds every output but cpu_reset_o, and nothing is judged while ce_i is low
    default disable iff (rst_i || por_i || !ce_i);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged in the next cycle");
    AST_SEL_LEGAL: assert property (clk_sel_o != CSC_CD_RSVD)
        else $error("reserved divide code selected");
    AST_SEL_VIA_DIV4: assert property ($changed(clk_sel_o) |->
        ($past(clk_sel_o) == CSC_CD_DIV4 || clk_sel_o == CSC_CD_DIV4))
        else $error("divide change skipped divide-by-4");
    AST_SLOW_BY_SW: assert property ($rose(clk_sel_o == CSC_CD_SLOW) |->
        $past(pmr_wr) || $past(pmr_wr, 2))
        else $error("slow mode entered without a register write");
    AST_MULT_NEEDS_EN: assert property (clk_sel_o == CSC_CD_MULT |-> mult_enable_o)
        else $error("multiplier selected while disabled");
    AST_EN_IN_DIV4: assert property ($changed(mult_enable_o) |->
        $past(clk_sel_o) == CSC_CD_DIV4)
        else $error("multiplier enable changed outside divide-by-4");
    AST_FACTOR_LOCK: assert property ($changed(mult_factor_sel_o) |-> !$past(mult_enable_o))
        else $error("factor changed while multiplier enabled");
    AST_TICK_GAP: assert property (machine_tick_o |=> !machine_tick_o [*3])
        else $error("machine ticks closer than four clocks");
    // Sync stages delay detection, so a few raw cycles of slack are allowed
    AST_FAIL_IDLE: assert property ($rose(cpu_reset_o) |-> idle_r >= CSC_FAIL_CNT - 11'h004)
        else $error("processor reset without oscillator failure");
    COV_SWITCHBACK: cover property (clk_sel_o == CSC_CD_SLOW ##1 clk_sel_o == CSC_CD_DIV4);
    COV_MULT: cover property (clk_sel_o == CSC_CD_MULT);
    COV_FAIL: cover property ($rose(cpu_reset_o));
endmodule

bind csc_clock_control csc_clock_control_chk #(.STAB_CYCLES(STAB_CYCLES)) u_chk
(
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .por_i(por_i), .osc_i(osc_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cpu_reset_o(cpu_reset_o), .clk_sel_o(clk_sel_o),
    .mult_factor_sel_o(mult_factor_sel_o), .mult_enable_o(mult_enable_o),
    .machine_tick_o(machine_tick_o)
);

// >>> csc_clock_control_tb.sv
`timescale 1ns/10ps
module csc_clock_control_tb;
    import csc_pkg::*;
    // Power-up reset is raised with rst_i so the fail flag and enable start known
    logic        clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, osc_i = 1'b0, osc_run = 1'b1;
    logic        ce_i = 1'b1;
    logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, cpu_reset_o;
    logic        mult_factor_sel_o, mult_enable_o, machine_tick_o;
    logic [1:0]  clk_sel_o;
    logic [2:0]  ph = 3'h0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdata;
    csc_cpu_t    cpu_i = '0;
    int          miscompares = 0, tests_run = 0;
    // Input byte beside expected {divide, enable, factor}, applied in order
    logic [11:0] rows [14] = '{12'h408, 12'hc0c, 12'h00c, 12'h808, 12'h008, 12'h889, 12'h98b,
                               12'h90b, 12'h183, 12'hd83, 12'h98b, 12'h889, 12'h98b, 12'h18b};
    logic [9:0]  ev [3] = '{10'h200, 10'h002, 10'h001};

    csc_clock_control #(.STAB_CYCLES(16)) uut
    (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .por_i(por_i), .osc_i(osc_i), .cpu_i(cpu_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'h1), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cpu_reset_o(cpu_reset_o), .clk_sel_o(clk_sel_o), .mult_factor_sel_o(mult_factor_sel_o),
        .mult_enable_o(mult_enable_o), .machine_tick_o(machine_tick_o)
    );

    initial forever #12.5 clk_i = ~clk_i;

    // Monitored oscillator: 16 clocks a period, far above the fail threshold
    always @(posedge clk_i)
    begin
        ph <= ph + 3'h1;
        if (osc_run && ph == 3'h0)
            osc_i <= ~osc_i;
    end
////////////////////////////////////////
    task automatic tally_and_finish(input bit hung);
        if (hung)
            miscompares++;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic step(inout int n, input int lim);
        @(posedge clk_i);
        n++;
        if (n > lim)
            tally_and_finish(1'b1);
    endtask

    task automatic wb(input logic [3:0] a, input logic we, input logic [7:0] d);
        int n;
        n = 0;
        wb_adr_i <= a;
        wb_we_i  <= we;
        wb_dat_i <= {24'h0, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        step(n, 50);
        while (wb_ack_o !== 1'b1)
            step(n, 50);
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string nm);
        wb(a, 1'b0, 8'h0);
        chk(nm, e, rdata);
    endtask

    task automatic pulse(input logic [9:0] m);
        cpu_i <= cpu_i | m;
        @(posedge clk_i);
        cpu_i <= cpu_i & ~m;
        @(posedge clk_i);
    endtask

    task automatic reset_pulse();
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Distance in clocks between two consecutive machine ticks
    task automatic gap(output int g);
        g = 0;
        while (machine_tick_o !== 1'b1)
            step(g, 3000);
        g = 0;
        step(g, 3000);
        while (machine_tick_o !== 1'b1)
            step(g, 3000);
    endtask
////////////////////////////////////////
    initial
    begin
        int n;
        int g;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 14; i++)
        begin
            wb(CSC_ADDR_PMR, 1'b1, rows[i][11:4]);
            repeat (2) @(posedge clk_i);
            chk("pmr_out", 32'(rows[i][3:0]), 32'({clk_sel_o, mult_enable_o, mult_factor_sel_o}));
        end
        repeat (20) @(posedge clk_i);
        rdchk(CSC_ADDR_RCON, 32'h8, "ready");
        reset_pulse();
        rdchk(CSC_ADDR_PMR, 32'h80, "pmr_reset");
        wb(CSC_ADDR_RCON, 1'b1, 8'h08);
        rdchk(CSC_ADDR_RCON, 32'h0, "ready_sw");
        cpu_i <= 10'h168;
        rdchk(CSC_ADDR_STATUS, 32'haa, "status");
        wb(CSC_ADDR_PMR, 1'b1, 8'hc0);
        chk("busy_sel", 32'h2, 32'(clk_sel_o));
        cpu_i <= 10'h0;
        rdchk(4'h2, 32'h0, "unmapped");
        gap(g);
        chk("div4_gap", 32'h4, 32'(g));
        rdchk(CSC_ADDR_STATUS, 32'h0, "level_idle");
        wb(CSC_ADDR_PMR, 1'b1, 8'he0);
        gap(g);
        gap(g);
        chk("slow_gap", 32'h400, 32'(g));
        for (int k = 0; k < 3; k++)
        begin
            wb(CSC_ADDR_PMR, 1'b1, 8'he0);
            chk("slow_sel", 32'h3, 32'(clk_sel_o));
            pulse(ev[k]);
            n = 0;
            while (clk_sel_o !== CSC_CD_DIV4)
                step(n, 20);
            chk("switchback", 32'h2, 32'(clk_sel_o));
        end
        repeat (50) @(posedge clk_i);
        chk("stay_div4", 32'h2, 32'(clk_sel_o));
        wb(CSC_ADDR_PMR, 1'b1, 8'hc0);
        for (int k = 0; k < 3; k++)
            pulse(ev[k]);
        chk("no_speedup", 32'h3, 32'(clk_sel_o));
        wb(CSC_ADDR_PMR, 1'b1, 8'h80);
        wb(CSC_ADDR_POWER_CONTROL_REG, 1'b1, 8'h10);
        osc_run <= 1'b0;
        n = 0;
        while (cpu_reset_o !== 1'b1)
            step(n, 1500);
        rdchk(CSC_ADDR_POWER_CONTROL_REG, 32'h30, "fail_flag");
        chk("cpu_reset", 32'h1, 32'(cpu_reset_o));
        osc_run <= 1'b1;
        n = 0;
        while (cpu_reset_o !== 1'b0)
            step(n, 60);
        reset_pulse();
        rdchk(CSC_ADDR_POWER_CONTROL_REG, 32'h30, "flag_kept");
        wb(CSC_ADDR_POWER_CONTROL_REG, 1'b1, 8'h00);
        rdchk(CSC_ADDR_POWER_CONTROL_REG, 32'h0, "flag_clear");
        // Clock enable low stands in for stop: the detector must still see the failure
        osc_run <= 1'b0;
        ce_i    <= 1'b0;
        repeat (1200) @(posedge clk_i);
        ce_i    <= 1'b1;
        chk("no_reset", 32'h0, 32'(cpu_reset_o));
        rdchk(CSC_ADDR_POWER_CONTROL_REG, 32'h20, "flag_only");
        osc_run <= 1'b1;
        // Let the monitor see the clock again, or the flag would set right after power-up
        repeat (30) @(posedge clk_i);
        por_i <= 1'b1;
        @(posedge clk_i);
        por_i <= 1'b0;
        @(posedge clk_i);
        rdchk(CSC_ADDR_POWER_CONTROL_REG, 32'h0, "por_clear");
        tally_and_finish(1'b0);
    end
endmodule
